// ==== sim/rit_mem_partner.sv ====
`timescale 1ns/10ps
// ****************************************************
// external bus master and refresh memory model
// ****************************************************
module rit_mem_partner (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // stimulus from the bench
  input wire logic hold,
  // pins from the device
  input wire logic refresh_strobe_pin_n,
  input wire logic ext_bus_grant,
  // pins to the device
  output logic ext_bus_req,
  // observations
  output int pulses,
  output int last_len,
  output int clashes
);
  int run_len;
  logic strobe_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_bus_req <= 1'b0;
      strobe_q <= 1'b1;
      run_len <= 0;
      pulses <= 0;
      last_len <= 0;
      clashes <= 0;
    end else begin
      // request only while the bench asks, following hold one clock later
      ext_bus_req <= hold;
      strobe_q <= refresh_strobe_pin_n;
      if (!refresh_strobe_pin_n) begin
        run_len <= run_len + 1;
      end else begin
        run_len <= 0;
      end
      if (strobe_q && !refresh_strobe_pin_n) begin
        pulses <= pulses + 1;
      end
      if (!strobe_q && refresh_strobe_pin_n) begin
        last_len <= run_len;
      end
      // a refresh strobe while the bus is ours is a fault
      if (!refresh_strobe_pin_n && ext_bus_grant) begin
        clashes <= clashes + 1;
      end
    end
  end
endmodule : rit_mem_partner

// ==== sim/tb.sv ====
`timescale 1ns/10ps
`include "rit_cfg.svh"
module tb;
  import rit_pkg::*;
  localparam int RC = 4;
  localparam logic [7:0] CTL = `RIT_OFS_CTRL_STATUS;
  localparam logic [7:0] CNT = `RIT_OFS_COUNTER;
  localparam logic [7:0] MAT = `RIT_OFS_MATCH;
  localparam logic [7:0] REF = `RIT_OFS_REFRESH_CTRL;
  localparam logic [7:0] REL = `RIT_OFS_BUS_RELEASE;
  localparam logic [7:0] PWR = `RIT_OFS_POWER;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rv, seed;
  logic dma_bus_req, bus_wait, hold, ext_bus_req;
  logic match_interrupt, refresh_strobe_pin_n, area3_chip_select_n;
  logic ext_bus_grant, dma_bus_grant;
  logic [7:0] c;
  int failures, num_checks, pulses, last_len, clashes, base;
  int mdl[8];

  rit_timer #(.REFRESH_CYCLES(RC)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_bus_req(ext_bus_req), .dma_bus_req(dma_bus_req),
    .bus_wait(bus_wait), .match_interrupt(match_interrupt),
    .refresh_strobe_pin_n(refresh_strobe_pin_n),
    .area3_chip_select_n(area3_chip_select_n),
    .ext_bus_grant(ext_bus_grant), .dma_bus_grant(dma_bus_grant));

  rit_mem_partner ptn (
    .hclk(hclk), .hresetn(hresetn), .hold(hold),
    .refresh_strobe_pin_n(refresh_strobe_pin_n),
    .ext_bus_grant(ext_bus_grant), .ext_bus_req(ext_bus_req),
    .pulses(pulses), .last_len(last_len), .clashes(clashes));

  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    if (a < 8'h18) begin
      mdl[a[4:2]] = int'(d);
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [7:0] m);
    rd(a);
    check(rv[7:0] & m, 8'(mdl[a[4:2]]) & m);
  endtask : rchk

  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      rd(CTL);
      n++;
    end while (rv[`RIT_BIT_MATCH_FLAG] !== 1'b1 && n < 400);
  endtask : wait_flag

  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // ****************************************************
  // clock and watchdog
  // ****************************************************
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial begin
    repeat (60000) @(posedge hclk);
    failures++;
    stop_test();
  end

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, dma_bus_req, bus_wait, hold} = 5'b0_0000;
    haddr = 8'h00;
    htrans = 2'b00;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    seed = 32'h0000_541c;
    mdl = '{0, 0, 255, 0, 0, 0, 0, 0};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(CTL);
    check(rv[7:0], 8'h00);
    check(8'(area3_chip_select_n), 8'h01);
    check(8'(hresp), 8'h00);
    rd(CNT);
    check(rv[7:0], `RIT_RST_COUNTER);
    rchk(MAT, 8'hff);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20);
    check(rv[7:0], 8'h00);
    // random traffic with the counter clock halted
    repeat (4) begin
      seed = xs(seed);
      wr(MAT, seed);
      rchk(MAT, 8'hff);
      wr(CNT, seed >> 8);
      rd(CNT);
      check(rv[7:0], seed[15:8]);
    end
    // refresh requests held back by release and by long waits
    wr(REF, 32'h0000_0001);
    rchk(REF, 8'h03);
    wr(REL, 32'h0000_0001);
    wr(MAT, 32'h0000_0060);
    wr(CNT, 32'h0000_0000);
    wr(CTL, 32'h0000_0008);
    wait_flag();
    check(rv[7:0], 8'h88);
    check(8'(pulses), 8'h00);
    for (int m = 0; m < 2; m++) begin
      base = pulses;
      if (m == 0) hold <= 1'b1;
      else bus_wait <= 1'b1;
      repeat (2) begin
        wr(CTL, 32'h0000_0008);
        wait_flag();
      end
      if (m == 0) check(8'(ext_bus_grant), 8'h01);
      check(8'(pulses - base), 8'h00);
      hold <= 1'b0;
      bus_wait <= 1'b0;
      repeat (16) @(posedge hclk);
      check(8'(pulses - base), 8'h01);
      check(8'(last_len), 8'(RC));
    end
    // arbitration between outside requesters
    wr(REF, 32'h0000_0000);
    hold <= 1'b1;
    dma_bus_req <= 1'b1;
    repeat (6) @(posedge hclk);
    check({6'h00, ext_bus_grant, dma_bus_grant}, 8'h02);
    hold <= 1'b0;
    repeat (6) @(posedge hclk);
    check({6'h00, ext_bus_grant, dma_bus_grant}, 8'h01);
    dma_bus_req <= 1'b0;
    // interval timer: match only on leaving equality
    wr(CTL, 32'h0000_0000);
    wr(MAT, 32'h0000_0005);
    wr(CNT, 32'h0000_0005);
    wr(CTL, 32'h0000_0040);
    repeat (20) @(posedge hclk);
    rd(CTL);
    check(rv[7:0], 8'h40);
    wr(CTL, 32'h0000_0058);
    wait_flag();
    check(rv[7:0], 8'hd8);
    rd(CNT);
    check(rv[7:0], 8'h00);
    check(8'(match_interrupt), 8'h01);
    wr(CTL, 32'h0000_0098);
    repeat (2) @(posedge hclk);
    check(8'(match_interrupt), 8'h00);
    // power modes
    wr(MAT, 32'h0000_00ff);
    wr(PWR, 32'h0000_0001);
    rd(CNT);
    c = rv[7:0];
    repeat (100) @(posedge hclk);
    rd(CNT);
    check(8'(rv[7:0] != c), 8'h01);
    wr(PWR, 32'h0000_0004);
    rd(CNT);
    c = rv[7:0];
    repeat (100) @(posedge hclk);
    rd(CNT);
    check(rv[7:0], c);
    wr(PWR, 32'h0000_0000);
    wr(REL, 32'h0000_0000);
    wr(CNT, 32'h0000_0040);
    wr(CTL, 32'h0000_00d8);
    wr(PWR, 32'h0000_0002);
    rd(CNT);
    check(rv[7:0], 8'h00);
    rd(CTL);
    check(rv[7:0], 8'h18);
    rchk(MAT, 8'hff);
    wr(PWR, 32'h0000_0000);
    check(8'(clashes), 8'h00);
    stop_test();
  end
endmodule : tb

// ==== verilog/rit_arbiter.sv ====
`timescale 1ns/10ps
// ****************************************************
// fixed priority bus arbiter
// ****************************************************
module rit_arbiter
  import rit_pkg::*;
(
  // requests
  input wire logic req_ext,
  input wire logic req_refresh,
  input wire logic req_dma,
  // decision
  output rit_grant_type grant
);
  always_comb begin
    if (req_ext) begin
      grant = RIT_GRANT_EXT;
    end else if (req_refresh) begin
      grant = RIT_GRANT_REFRESH;
    end else if (req_dma) begin
      grant = RIT_GRANT_DMA;
    end else begin
      grant = RIT_GRANT_CPU;
    end
  end
endmodule : rit_arbiter

// ==== verilog/rit_cfg.svh ====
`ifndef RIT_CFG_SVH
`define RIT_CFG_SVH
// ****************************************************
// register byte offsets
// ****************************************************
`define RIT_OFS_CTRL_STATUS 8'h00
`define RIT_OFS_COUNTER 8'h04
`define RIT_OFS_MATCH 8'h08
`define RIT_OFS_REFRESH_CTRL 8'h0C
`define RIT_OFS_BUS_RELEASE 8'h10
`define RIT_OFS_POWER 8'h14
// ****************************************************
// timer control/status field positions
// ****************************************************
`define RIT_BIT_MATCH_FLAG 7
`define RIT_BIT_MATCH_IRQ_EN 6
`define RIT_POS_CLK_SEL 3
// ****************************************************
// refresh control field positions
// ****************************************************
`define RIT_BIT_DYN_MEM_EN 0
`define RIT_BIT_PSEUDO_EN 1
// ****************************************************
// reset values
// ****************************************************
`define RIT_RST_COUNTER 8'h00
`define RIT_RST_MATCH 8'hFF
`define RIT_RST_CLK_SEL 3'h0
// ****************************************************
// timing
// ****************************************************
`define RIT_CLK_PERIOD_NS 4
`define RIT_LONG_WAIT_NS 64
`define RIT_LONG_WAIT_CYC (`RIT_LONG_WAIT_NS / `RIT_CLK_PERIOD_NS)
`endif

// ==== verilog/rit_pkg.sv ====
package rit_pkg;
  typedef enum logic [1:0] {
    RIT_IDLE = 2'b00,
    RIT_WAIT_BUS = 2'b01,
    RIT_CYCLE = 2'b11
  } rit_refresh_state_type;

  typedef enum logic [1:0] {
    RIT_GRANT_CPU = 2'b00,
    RIT_GRANT_DMA = 2'b01,
    RIT_GRANT_REFRESH = 2'b10,
    RIT_GRANT_EXT = 2'b11
  } rit_grant_type;
endpackage : rit_pkg

// ==== verilog/rit_prescaler.sv ====
`timescale 1ns/10ps
`include "rit_cfg.svh"
// ****************************************************
// free running divider giving the prescaled clock sources
// ****************************************************
module rit_prescaler #(
  parameter int DIV_BITS = 13
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic run,
  // prescaled levels
  output logic [DIV_BITS-1:0] div_levels
);
  typedef struct packed {
    logic [DIV_BITS-1:0] count;
  } rit_prescaler_state_type;

  rit_prescaler_state_type state;
  rit_prescaler_state_type next_state;

  always_comb begin
    next_state = state;
    if (run) begin
      next_state.count = state.count + {{(DIV_BITS-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign div_levels = state.count;
endmodule : rit_prescaler

// ==== verilog/rit_timer.sv ====
`timescale 1ns/10ps
`include "rit_cfg.svh"
// Behaviour
// - match signal sets the match flag to one.
// - match signal fires when counter leaves the matching value.
// - timer runs in sleep, stops fully in hardware standby.
// - software standby resets counter and flag bits 7, 6 only.
// - a counter clear beats a simultaneous counter write.
// - a counter write beats a simultaneous increment.
// - a match register write suppresses a simultaneous compare match.
// - counter clock is the falling edge of selected prescaled source.
// - source switch from high to low counts as one falling edge.
// - match interrupt requested when flag set and enable bit set.
// - a counter write with dynamic memory enabled drives chip select low.
// - no refresh starts while released, in software standby, or long wait.
// - requests during bus release collapse into one later refresh.
// - requests during long waits are held as one pending refresh.
// - standby entry racing a bus request may release bus one state.
// - grant order: external master, refresh, dma, processor.
// - first refresh request after reset or standby runs no cycle.
module rit_timer
  import rit_pkg::*;
#(
  parameter int REFRESH_CYCLES = 4
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // bus environment
  input wire logic ext_bus_req,
  input wire logic dma_bus_req,
  input wire logic bus_wait,
  // memory, interrupt and bus grant pins
  output logic match_interrupt,
  output logic refresh_strobe_pin_n,
  output logic area3_chip_select_n,
  output logic ext_bus_grant,
  output logic dma_bus_grant
);
  localparam int WAIT_CYC = `RIT_LONG_WAIT_CYC;

  typedef struct packed {
    logic [7:0] refresh_counter;
    logic [7:0] match_constant_reg;
    logic match_flag;
    logic match_irq_enable;
    logic [2:0] clock_select_field;
    logic dyn_mem_enable;
    logic pseudo_static_enable;
    logic bus_release_enable;
    logic sleep_mode;
    logic soft_standby;
    logic hard_standby;
    logic was_match;
    logic src_prev;
    logic first_req_done;
    logic pending;
    logic [7:0] wait_count;
    logic [2:0] cyc_count;
    rit_refresh_state_type fsm;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic irq;
    logic strobe_n;
    logic cs3_n;
    logic ext_gnt;
    logic dma_gnt;
  } rit_state_type;

  rit_state_type state;
  rit_state_type next_state;
  logic [12:0] div_levels;
  logic src_level;
  rit_grant_type grant;
  logic ext_sync1;
  logic ext_sync2;

  // ****************************************************
  // prescaler and arbiter
  // ****************************************************
  rit_prescaler #(.DIV_BITS(13)) u_prescaler (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(!state.hard_standby && !state.soft_standby),
    .div_levels(div_levels)
  );

  rit_arbiter u_arbiter (
    .req_ext(ext_sync2 && state.bus_release_enable),
    .req_refresh(state.fsm != RIT_IDLE),
    .req_dma(dma_bus_req),
    .grant(grant)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
    end else begin
      ext_sync1 <= ext_bus_req;
      ext_sync2 <= ext_sync1;
    end
  end

  // selected source; code 0 is the halted state
  always_comb begin
    unique case (state.clock_select_field)
      3'd0: src_level = 1'b0;
      3'd1: src_level = div_levels[0];
      3'd2: src_level = div_levels[2];
      3'd3: src_level = div_levels[4];
      3'd4: src_level = div_levels[6];
      3'd5: src_level = div_levels[8];
      3'd6: src_level = div_levels[10];
      3'd7: src_level = div_levels[12];
    endcase
  end

  // ****************************************************
  // next state
  // ****************************************************
  logic incr;
  logic match_sig;
  logic wr_cnt;
  logic wr_match;
  logic addr_phase;
  logic [7:0] wd;

  always_comb begin
    next_state = state;
    wd = hwdata[7:0];
    addr_phase = hsel && htrans[1] && hready;
    wr_cnt = state.wr_pend && state.wr_addr == `RIT_OFS_COUNTER;
    wr_match = state.wr_pend && state.wr_addr == `RIT_OFS_MATCH;
    next_state.src_prev = src_level;
    // source falling, including a high to low switchover
    incr = state.src_prev && !src_level && !state.hard_standby
      && !state.soft_standby;
    // match leaves on the counter clock after equality
    match_sig = incr && state.was_match && !wr_match;
    if (incr) begin
      next_state.was_match =
        (state.refresh_counter + 8'h01) == state.match_constant_reg;
    end
    if (match_sig) begin
      next_state.refresh_counter = `RIT_RST_COUNTER;
      next_state.was_match = state.match_constant_reg == 8'h00;
      next_state.match_flag = 1'b1;
    end else if (wr_cnt) begin
      next_state.refresh_counter = wd;
      next_state.was_match = wd == state.match_constant_reg;
    end else if (incr) begin
      next_state.refresh_counter = state.refresh_counter + 8'h01;
    end
    // bus write data phase
    next_state.wr_pend = 1'b0;
    if (state.wr_pend) begin
      unique case (state.wr_addr)
        `RIT_OFS_CTRL_STATUS: begin
          if (!wd[`RIT_BIT_MATCH_FLAG] && !match_sig) begin
            next_state.match_flag = 1'b0;
          end
          next_state.match_irq_enable = wd[`RIT_BIT_MATCH_IRQ_EN];
          next_state.clock_select_field = wd[`RIT_POS_CLK_SEL +: 3];
        end
        `RIT_OFS_MATCH: begin
          next_state.match_constant_reg = wd;
          next_state.was_match = state.refresh_counter == wd;
        end
        `RIT_OFS_REFRESH_CTRL: begin
          next_state.dyn_mem_enable = wd[`RIT_BIT_DYN_MEM_EN];
          next_state.pseudo_static_enable = wd[`RIT_BIT_PSEUDO_EN];
        end
        `RIT_OFS_BUS_RELEASE: next_state.bus_release_enable = wd[0];
        `RIT_OFS_POWER: begin
          next_state.sleep_mode = wd[0];
          next_state.soft_standby = wd[1];
          next_state.hard_standby = wd[2];
        end
        default: ;
      endcase
    end
    if (addr_phase) begin
      next_state.wr_pend = hwrite;
      next_state.wr_addr = haddr;
      unique case (haddr)
        `RIT_OFS_CTRL_STATUS: next_state.rdata = {24'h00_0000,
          state.match_flag, state.match_irq_enable,
          state.clock_select_field, 3'h0};
        `RIT_OFS_COUNTER: next_state.rdata = {24'h00_0000,
          state.refresh_counter};
        `RIT_OFS_MATCH: next_state.rdata = {24'h00_0000,
          state.match_constant_reg};
        `RIT_OFS_REFRESH_CTRL: next_state.rdata = {30'h0000_0000,
          state.pseudo_static_enable, state.dyn_mem_enable};
        `RIT_OFS_BUS_RELEASE: next_state.rdata = {31'h0000_0000,
          state.bus_release_enable};
        `RIT_OFS_POWER: next_state.rdata = {29'h0000_0000,
          state.hard_standby, state.soft_standby, state.sleep_mode};
        default: next_state.rdata = 32'h0000_0000;
      endcase
    end
    // refresh request sequencing
    if (bus_wait) begin
      if (state.wait_count != 8'hFF) begin
        next_state.wait_count = state.wait_count + 8'h01;
      end
    end else begin
      next_state.wait_count = 8'h00;
    end
    if (match_sig && (state.dyn_mem_enable || state.pseudo_static_enable))
    begin
      if (!state.first_req_done) begin
        next_state.first_req_done = 1'b1;
      end else begin
        next_state.pending = 1'b1;
      end
    end
    unique case (state.fsm)
      RIT_IDLE: begin
        if (state.pending) begin
          next_state.fsm = RIT_WAIT_BUS;
        end
      end
      RIT_WAIT_BUS: begin
        // one held request waits out release and long waits
        if (grant == RIT_GRANT_REFRESH && !bus_wait
          && !state.soft_standby) begin
          next_state.fsm = RIT_CYCLE;
          next_state.pending = 1'b0;
          next_state.cyc_count = 3'h0;
        end
      end
      RIT_CYCLE: begin
        next_state.cyc_count = state.cyc_count + 3'h1;
        if (state.cyc_count == 3'(REFRESH_CYCLES - 1)) begin
          next_state.fsm = RIT_IDLE;
        end
      end
      default: next_state.fsm = RIT_IDLE;
    endcase
    // software or hardware standby
    if (state.soft_standby || state.hard_standby) begin
      next_state.refresh_counter = `RIT_RST_COUNTER;
      next_state.match_flag = 1'b0;
      next_state.match_irq_enable = 1'b0;
      next_state.was_match = 1'b0;
      next_state.first_req_done = 1'b0;
      next_state.pending = 1'b0;
      next_state.fsm = RIT_IDLE;
    end
    next_state.irq = next_state.match_flag
      && next_state.match_irq_enable;
    // strobe held low only by its own refresh; cs3 low on counter write while enabled
    next_state.strobe_n = !(next_state.fsm == RIT_CYCLE);
    next_state.cs3_n = !(next_state.dyn_mem_enable
      && state.wr_pend && state.wr_addr == `RIT_OFS_COUNTER);
    next_state.ext_gnt = grant == RIT_GRANT_EXT;
    next_state.dma_gnt = grant == RIT_GRANT_DMA;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
      state.match_constant_reg <= `RIT_RST_MATCH;
      state.clock_select_field <= `RIT_RST_CLK_SEL;
      state.strobe_n <= 1'b1;
      state.cs3_n <= 1'b1;
      state.fsm <= RIT_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign hrdata = state.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign match_interrupt = state.irq;
  assign refresh_strobe_pin_n = state.strobe_n;
  assign area3_chip_select_n = state.cs3_n;
  assign ext_bus_grant = state.ext_gnt;
  assign dma_bus_grant = state.dma_gnt;

  // ****************************************************
  // assertions
  // ****************************************************
  property p_flag_set;
    @(posedge hclk) disable iff (!hresetn)
    match_sig && !state.soft_standby && !state.hard_standby
      |=> state.match_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("match flag not set after match");

  property p_match_late;
    @(posedge hclk) disable iff (!hresetn)
    match_sig |-> $past(state.refresh_counter == state.match_constant_reg);
  endproperty
  a_match_late: assert property (p_match_late)
    else $error("match fired without prior equality");

  property p_clear;
    @(posedge hclk) disable iff (!hresetn)
    match_sig |=> state.refresh_counter == 8'h00;
  endproperty
  a_clear: assert property (p_clear)
    else $error("counter not cleared on match");

  property p_hard_stop;
    @(posedge hclk) disable iff (!hresetn)
    state.hard_standby |-> !incr;
  endproperty
  a_hard_stop: assert property (p_hard_stop)
    else $error("counter clock ran in hardware standby");

  property p_soft_keep;
    @(posedge hclk) disable iff (!hresetn)
    state.soft_standby && !state.wr_pend |=>
      state.refresh_counter == 8'h00 && !state.match_flag
      && $stable(state.match_constant_reg);
  endproperty
  a_soft_keep: assert property (p_soft_keep)
    else $error("standby reset wrong");

  property p_write_wins;
    @(posedge hclk) disable iff (!hresetn)
    wr_cnt && !match_sig && !state.soft_standby && !state.hard_standby
      |=> state.refresh_counter == $past(hwdata[7:0]);
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("counter write lost to increment");

  property p_match_inhibit;
    @(posedge hclk) disable iff (!hresetn)
    wr_match |-> !match_sig;
  endproperty
  a_match_inhibit: assert property (p_match_inhibit)
    else $error("match not inhibited by match write");

  property p_irq;
    @(posedge hclk) disable iff (!hresetn)
    state.match_flag && state.match_irq_enable && !state.soft_standby
      && !state.hard_standby && !state.wr_pend |=> match_interrupt;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt missing");

  property p_no_refresh;
    @(posedge hclk) disable iff (!hresetn)
    state.fsm == RIT_WAIT_BUS && (ext_sync2 && state.bus_release_enable)
      |=> state.fsm != RIT_CYCLE;
  endproperty
  a_no_refresh: assert property (p_no_refresh)
    else $error("refresh ran while bus released");

  property p_priority;
    @(posedge hclk) disable iff (!hresetn)
    ext_sync2 && state.bus_release_enable |=> ext_bus_grant;
  endproperty
  a_priority: assert property (p_priority)
    else $error("external master not granted first");
endmodule : rit_timer
